// >>> rtl/i2sc_defines.vh
// constants for the i2c master start/collision sequencer
`ifndef I2SC_DEFINES_VH
`define I2SC_DEFINES_VH
`define I2SC_RELOAD_W 7
`define I2SC_RELOAD_RST 7'h00
`endif

// >>> rtl/i2sc_master.v
// i2c master sequencer: start, repeated start, stop, clock arbitration, collision
// Operation
// - counter pauses while released scl stays low
// - scl seen high reloads counter, counting resumes
// - byte or address match wakes sleeping core
// - reset or enable low aborts transfer
// - bus already low at start: collision, idle
// - start counts from sda high; scl low collides
// - sda low during first count: drive early
// - second count ignores scl low, then scl low
// - repeated start: sda low at scl high collides
// - sda falling before expiry is no collision
// - scl falling before sda driven collides
// - both high at timeout: drive sda, count, scl
`timescale 1ns/100ps
`include "i2sc_defines.vh"
module i2sc_master #(
  parameter RW = `I2SC_RELOAD_W
) (
  input wire mclk_i,
  input wire rst_i,
  input wire enable_i,
  input wire [RW-1:0] baud_reload_value_i,
  input wire start_req_i,
  input wire rstart_req_i,
  input wire stop_req_i,
  input wire scl_rel_i,
  input wire sda_rel_i,
  input wire sleep_i,
  input wire irq_en_i,
  input wire byte_done_i,
  input wire addr_match_i,
  input wire bus_flag_clr_i,
  input wire scl_i,
  input wire sda_i,
  output reg scl_o,
  output reg scl_oe_o,
  output reg sda_o,
  output reg sda_oe_o,
  output reg bus_collision_flag_o,
  output reg busy_o,
  output reg done_o,
  output reg wake_o
);
  // =====================================================
  // pin synchronisers
  reg scl_m_ff, scl_s_ff, sda_m_ff, sda_s_ff;
  always @(posedge mclk_i) begin
    if (rst_i) begin
      scl_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
    end else begin
      scl_m_ff <= scl_i;
      scl_s_ff <= scl_m_ff;
      sda_m_ff <= sda_i;
      sda_s_ff <= sda_m_ff;
    end
  end
  // =====================================================
  // state and drive
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_S_CHK = 4'h1;
  localparam [3:0] ST_S_CNT1 = 4'h2;
  localparam [3:0] ST_S_CNT2 = 4'h3;
  localparam [3:0] ST_R_CNT1 = 4'h4;
  localparam [3:0] ST_R_SCLW = 4'h5;
  localparam [3:0] ST_R_CNT2 = 4'h6;
  localparam [3:0] ST_R_CNT3 = 4'h7;
  localparam [3:0] ST_P_CNT1 = 4'h9;
  localparam [3:0] ST_P_SCLW = 4'ha;
  localparam [3:0] ST_P_CNT2 = 4'hb;
  reg [3:0] st_ff, nxt_st;
  reg scl_dr_ff, nxt_scl_dr, sda_dr_ff, nxt_sda_dr;
  reg load, run, coll, fin;
  wire tz;
  i2sc_tick #(.W(RW)) u_tick (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .load_i(load),
    .run_i(run),
    .reload_i(baud_reload_value_i),
    .zero_o(tz)
  );
  always @* begin
    nxt_st = st_ff;
    nxt_scl_dr = scl_dr_ff;
    nxt_sda_dr = sda_dr_ff;
    load = 1'b0;
    run = 1'b0;
    coll = 1'b0;
    fin = 1'b0;
    case (st_ff)
      ST_IDLE: begin
        if (enable_i && start_req_i) begin
          nxt_st = ST_S_CHK;
        end else if (enable_i && rstart_req_i) begin
          nxt_scl_dr = 1'b1;
          nxt_sda_dr = 1'b0;
          load = 1'b1;
          nxt_st = ST_R_CNT1;
        end else if (enable_i && stop_req_i) begin
          nxt_scl_dr = 1'b1;
          nxt_sda_dr = 1'b1;
          load = 1'b1;
          nxt_st = ST_P_CNT1;
        end
      end
      ST_S_CHK: begin
        if (!sda_s_ff || !scl_s_ff) begin
          coll = 1'b1;
        end else begin
          load = 1'b1;
          nxt_st = ST_S_CNT1;
        end
      end
      ST_S_CNT1: begin
        run = 1'b1;
        if (!scl_s_ff && sda_s_ff) begin
          coll = 1'b1;
        end else if (!sda_s_ff || tz) begin
          // early drive on sda low keeps both starting masters in step
          nxt_sda_dr = 1'b1;
          load = 1'b1;
          nxt_st = ST_S_CNT2;
        end
      end
      ST_S_CNT2: begin
        run = 1'b1;
        if (tz) begin
          nxt_scl_dr = 1'b1;
          fin = 1'b1;
        end
      end
      ST_R_CNT1: begin
        run = 1'b1;
        if (tz) begin
          nxt_scl_dr = 1'b0;
          nxt_st = ST_R_SCLW;
        end
      end
      ST_R_SCLW: begin
        if (scl_s_ff) begin
          if (!sda_s_ff) begin
            coll = 1'b1;
          end else begin
            load = 1'b1;
            nxt_st = ST_R_CNT2;
          end
        end
      end
      ST_R_CNT2: begin
        run = 1'b1;
        if (!scl_s_ff && sda_s_ff) begin
          coll = 1'b1;
        end else if (tz && scl_s_ff && sda_s_ff) begin
          nxt_sda_dr = 1'b1;
          load = 1'b1;
          nxt_st = ST_R_CNT3;
        end else if (!sda_s_ff && (tz || !scl_s_ff)) begin
          // another master already pulled sda: same start, keep going
          nxt_sda_dr = 1'b1;
          load = 1'b1;
          nxt_st = ST_R_CNT3;
        end
      end
      ST_R_CNT3: begin
        run = 1'b1;
        if (tz) begin
          nxt_scl_dr = 1'b1;
          fin = 1'b1;
        end
      end
      ST_P_CNT1: begin
        // both lines held low for a full count first, so the release below
        // starts from a known low scl and a stale high sample cannot slip in
        run = 1'b1;
        if (tz) begin
          nxt_scl_dr = 1'b0;
          nxt_st = ST_P_SCLW;
        end
      end
      ST_P_SCLW: begin
        // hold the counter until released scl is really high
        if (scl_s_ff) begin
          load = 1'b1;
          nxt_st = ST_P_CNT2;
        end
      end
      ST_P_CNT2: begin
        run = 1'b1;
        if (tz) begin
          nxt_sda_dr = 1'b0;
          fin = 1'b1;
        end
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
    if (coll) begin
      nxt_st = ST_IDLE;
      nxt_scl_dr = 1'b0;
      nxt_sda_dr = 1'b0;
    end else if (fin) begin
      // start and repeated start leave the bus held for the byte engine that follows; stop ends with both lines released
      nxt_st = ST_IDLE;
    end
    if (!enable_i) begin
      nxt_st = ST_IDLE;
      nxt_scl_dr = 1'b0;
      nxt_sda_dr = 1'b0;
    end
  end
  always @(posedge mclk_i) begin
    if (rst_i) begin
      st_ff <= ST_IDLE;
      scl_dr_ff <= 1'b0;
      sda_dr_ff <= 1'b0;
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      bus_collision_flag_o <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      scl_dr_ff <= nxt_scl_dr;
      sda_dr_ff <= nxt_sda_dr;
      scl_oe_o <= nxt_scl_dr;
      sda_oe_o <= nxt_sda_dr;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      // set wins over clear
      if (coll) begin
        bus_collision_flag_o <= 1'b1;
      end else if (bus_flag_clr_i) begin
        bus_collision_flag_o <= 1'b0;
      end
      busy_o <= (nxt_st != ST_IDLE);
      done_o <= fin && !coll && enable_i;
      wake_o <= enable_i && sleep_i && irq_en_i && (byte_done_i || addr_match_i);
    end
  end
endmodule

// >>> rtl/i2sc_tick.v
// baud tick counter: down-counter reloaded from the 7-bit reload value
`timescale 1ns/100ps
`include "i2sc_defines.vh"
module i2sc_tick #(
  parameter W = `I2SC_RELOAD_W
) (
  input wire mclk_i,
  input wire rst_i,
  input wire load_i,
  input wire run_i,
  input wire [W-1:0] reload_i,
  output wire zero_o
);
  reg [W-1:0] cnt_ff;
  reg [W-1:0] nxt_cnt;
  always @* begin
    nxt_cnt = cnt_ff;
    if (load_i) begin
      nxt_cnt = reload_i;
    end else if (run_i && cnt_ff != {W{1'b0}}) begin
      nxt_cnt = cnt_ff - {{(W-1){1'b0}}, 1'b1};
    end
  end
  always @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_ff <= {W{1'b0}};
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
  assign zero_o = (cnt_ff == {W{1'b0}});
endmodule

// >>> testbench/i2sc_bus_model.sv
// open-drain bus with pull-ups and a far-side device that can hold either line
`timescale 1ns/100ps
module i2sc_bus_model (
  input wire scl_oe_i,
  input wire sda_oe_i,
  input wire stretch_i,
  input wire pull_sda_i,
  output wire scl_o,
  output wire sda_o
);
  // wired-and: released lines float to the pull-up level
  assign scl_o = !(scl_oe_i || stretch_i);
  assign sda_o = !(sda_oe_i || pull_sda_i);
endmodule

// >>> testbench/i2sc_master_assertions.sv
// checker for the i2c master sequencer
`timescale 1ns/100ps
module i2sc_master_chk (
  input wire mclk_i,
  input wire rst_i,
  input wire enable_i,
  input wire start_req_i,
  input wire scl_i,
  input wire sda_i,
  input wire sleep_i,
  input wire irq_en_i,
  input wire byte_done_i,
  input wire busy_o,
  input wire done_o,
  input wire wake_o,
  input wire scl_oe_o,
  input wire sda_oe_o,
  input wire bus_collision_flag_o
);
  // ====
  // sequences
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence taken_s;
    !busy_o && enable_i && start_req_i;
  endsequence
  // three samples low so the 2-stage synchroniser has surely seen it
  sequence sda_low_s;
    !sda_i && !$past(sda_i) && !$past(sda_i, 2);
  endsequence
  // ====
  // checks
  rst_abort_a: assert property (disable iff (1'b0) rst_i |=> !busy_o && !scl_oe_o && !sda_oe_o)
    else $error("reset left bus held");
  start_take_a: assert property (taken_s |=> busy_o)
    else $error("start not taken");
  start_min_a: assert property (taken_s |=> !done_o [*5])
    else $error("start too short");
  start_end_a: assert property (taken_s ##0 scl_i && sda_i |-> ##[1:400] done_o || bus_collision_flag_o)
    else $error("start never ended");
  low_coll_a: assert property (taken_s ##0 sda_low_s |-> ##[1:4] bus_collision_flag_o)
    else $error("low bus not flagged");
  coll_idle_a: assert property ($rose(bus_collision_flag_o) |-> ##[0:1] !busy_o && !scl_oe_o && !sda_oe_o)
    else $error("collision kept bus");
  sda_first_a: assert property (done_o && scl_oe_o |-> sda_oe_o)
    else $error("scl pulled before sda");
  wake_up_a: assert property (sleep_i && irq_en_i && byte_done_i |-> ##[1:3] wake_o)
    else $error("no wake");
endmodule
bind i2sc_master i2sc_master_chk i2sc_master_chk_inst (.mclk_i, .rst_i, .enable_i, .start_req_i,
  .scl_i, .sda_i, .sleep_i, .irq_en_i, .byte_done_i, .busy_o, .done_o, .wake_o, .scl_oe_o,
  .sda_oe_o, .bus_collision_flag_o);

// >>> testbench/i2sc_master_bench.sv
// self-checking bench for the i2c master sequencer
`timescale 1ns/100ps
module i2sc_master_bench;
  localparam [6:0] RL = 7'h10;
  logic mclk_i = 0, rst_i = 1, en = 1, s_req = 0, r_req = 0, p_req = 0, clr = 0;
  logic sleep_i = 0, irq_en_i = 0, byte_done_i = 0, addr_match = 0, stretch = 0, pull_sda = 0;
  wire scl, sda, scl_oe, sda_oe, flag, busy, done, wake;
  integer failures = 0, n_tests = 0, n;
  i2sc_master i2sc_master_inst (.mclk_i(mclk_i), .rst_i(rst_i), .enable_i(en),
    .baud_reload_value_i(RL), .start_req_i(s_req), .rstart_req_i(r_req), .stop_req_i(p_req),
    .scl_rel_i(1'b0), .sda_rel_i(1'b0), .sleep_i(sleep_i), .irq_en_i(irq_en_i),
    .byte_done_i(byte_done_i), .addr_match_i(addr_match), .bus_flag_clr_i(clr), .scl_i(scl),
    .sda_i(sda), .scl_o(), .scl_oe_o(scl_oe), .sda_o(), .sda_oe_o(sda_oe),
    .bus_collision_flag_o(flag), .busy_o(busy), .done_o(done), .wake_o(wake));
  i2sc_bus_model i2sc_bus_model_inst (.scl_oe_i(scl_oe), .sda_oe_i(sda_oe),
    .stretch_i(stretch), .pull_sda_i(pull_sda), .scl_o(scl), .sda_o(sda));
  initial forever #2.5 mclk_i = ~mclk_i;
  task end_sim;
    if (failures == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input string nm, input [3:0] e, input [3:0] g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // e is {done, flag, sda pulled, scl pulled}; a collision is judged one cycle on
  task req(input [2:0] k, input [3:0] e, input string nm);
    @(negedge mclk_i);
    clr = 1;
    {s_req, r_req, p_req} = k;
    @(negedge mclk_i);
    clr = 0;
    {s_req, r_req, p_req} = 3'h0;
    n = 1;
    while (done !== 1'b1 && flag !== 1'b1 && n < 4000) begin
      @(negedge mclk_i);
      n = n + 1;
    end
    if (e[2]) @(negedge mclk_i);
    chk(nm, e, {done, flag, sda_oe, scl_oe});
  endtask
  initial begin
    #50000;
    failures = failures + 1;
    end_sim;
  end
  initial begin
    repeat (8) @(negedge mclk_i);
    rst_i = 0;
    repeat (3) @(negedge mclk_i);
    req(3'h4, 4'hb, "start");
    chk("start length", 4'h1, {3'h0, n == 2 * (RL + 1) + 2});
    fork
      req(3'h2, 4'h4, "rstart sda low");
      begin
        while (scl_oe !== 1'b0) @(negedge mclk_i);
        stretch = 1;
        pull_sda = 1;
        repeat (32) @(negedge mclk_i);
        stretch = 0;
      end
    join
    pull_sda = 0;
    fork
      req(3'h4, 4'hb, "early sda start");
      begin
        repeat (6) @(negedge mclk_i);
        pull_sda = 1;
      end
    join
    pull_sda = 0;
    chk("early start length", 4'h1, {3'h0, n < 2 * (RL + 1) + 2});
    req(3'h2, 4'hb, "rstart");
    stretch = 1;
    fork
      req(3'h1, 4'h8, "stop");
      begin
        repeat (64) @(negedge mclk_i);
        stretch = 0;
      end
    join
    chk("stretch length", 4'h1, {3'h0, n >= 64 + RL});
    fork
      req(3'h2, 4'h4, "rstart scl low");
      begin
        while (scl_oe !== 1'b1) @(negedge mclk_i);
        while (scl_oe !== 1'b0) @(negedge mclk_i);
        repeat (8) @(negedge mclk_i);
        stretch = 1;
      end
    join
    stretch = 0;
    fork
      req(3'h4, 4'h4, "start scl low");
      begin
        repeat (6) @(negedge mclk_i);
        stretch = 1;
      end
    join
    stretch = 0;
    fork
      req(3'h2, 4'hb, "rstart sda early");
      begin
        while (scl_oe !== 1'b1) @(negedge mclk_i);
        while (scl_oe !== 1'b0) @(negedge mclk_i);
        repeat (8) @(negedge mclk_i);
        pull_sda = 1;
      end
    join
    pull_sda = 1;
    req(3'h4, 4'h4, "start on low bus");
    pull_sda = 0;
    sleep_i = 1;
    irq_en_i = 1;
    byte_done_i = 1;
    @(negedge mclk_i);
    byte_done_i = 0;
    addr_match = 1;
    chk("wake byte", 4'h1, {3'h0, wake});
    @(negedge mclk_i);
    addr_match = 0;
    irq_en_i = 0;
    byte_done_i = 1;
    chk("wake addr", 4'h1, {3'h0, wake});
    @(negedge mclk_i);
    byte_done_i = 0;
    chk("wake masked", 4'h0, {3'h0, wake});
    sleep_i = 0;
    s_req = 1;
    @(negedge mclk_i);
    s_req = 0;
    repeat (25) @(negedge mclk_i);
    en = 0;
    @(negedge mclk_i);
    en = 1;
    chk("disable abort", 4'h0, {1'b0, busy, sda_oe, scl_oe});
    s_req = 1;
    @(negedge mclk_i);
    s_req = 0;
    repeat (25) @(negedge mclk_i);
    rst_i = 1;
    @(negedge mclk_i);
    rst_i = 0;
    chk("reset abort", 4'h0, {1'b0, busy, sda_oe, scl_oe});
    end_sim;
  end
endmodule
